// ---- hdl/psv_pkg.sv ----
// psv_pkg: constants and types for the startup sequencer and wiper logic
// assumes a 20 MHz core clock; analog comparators arrive asynchronously
package psv_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned LOAD_TIME_NS    = 120_000;
  localparam int unsigned SOFT_START_NS   = 500_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  // least times, rounded up to whole cycles
  localparam int unsigned LOAD_CYCLES     = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFT_CYCLES     = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WIPER_W         = 8;
  localparam logic [7:0]  WIPER_DEFAULT   = 8'h80;
  localparam logic [7:0]  WIPER_FULL      = 8'hFF;
  localparam logic [7:0]  PTR_NV_WORD     = 8'h00;
  localparam logic [7:0]  PTR_VOL_WORD    = 8'h80;
  localparam int unsigned PTR_SEL_BIT     = 7;
  localparam int unsigned TIMER_W         = 16;

  typedef enum logic [5:0] {
    PSV_ST_LOCKOUT = 6'b000001,
    PSV_ST_LOAD    = 6'b000010,
    PSV_ST_SOFT    = 6'b000100,
    PSV_ST_WAIT_EN = 6'b001000,
    PSV_ST_BOOST   = 6'b010000,
    PSV_ST_RUN     = 6'b100000
  } psv_state_t;

  // settled comparator levels
  typedef struct packed {
    logic lockout;
    logic rail_good;
    logic delay_charged;
  } psv_sense_t;

  // analog enables driven out
  typedef struct packed {
    logic ldo_enable;
    logic boost_enable;
    logic gate_pulse_release;
  } psv_ctrl_t;

  // wiper word write from the serial slave
  typedef struct packed {
    logic       write;
    logic       to_nv;
    logic [7:0] data;
  } psv_wr_t;
endpackage : psv_pkg

// ---- hdl/psv_seq.sv ----
// psv_seq: power-up sequencer plus common-voltage wiper word holder
// assumes a serial slave outside delivers wiper writes and error pulses,
// and analog blocks consume the enables and the sink-current code
`timescale 1ns/1ps

// Operation
// - wiper word of 8 bits gives 256 output steps
// - sink code is 255 minus wiper, larger code less current
// - wiper starts at 128 before any programming
// - serial bus error forces wiper back to 128, except during settings load where it is ignored
// - 120 us settings load after lockout clears, outputs stay off
// - logic regulator enabled only after load, 0.5 ms soft start
// - boost runs only while rail good and enable high together
// - gate pulse output low until delay node comparator trips
// - stored initial word copied into wiper during power-up
// - pointer defaults 00h after power-up; 80h selects volatile wiper
module psv_seq
  import psv_pkg::*;
#(
  parameter int unsigned LOAD_CNT = LOAD_CYCLES,
  parameter int unsigned SOFT_CNT = SOFT_CYCLES
) (
  input  wire logic         ref_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         clk_en_in,
  input  wire logic         lockout_in,
  input  wire logic         rail_good_in,
  input  wire logic         delay_charged_in,
  input  wire logic         ext_enable_in,
  input  wire logic [7:0]   stored_initial_wiper_in,
  input  wire logic         bus_error_in,
  input  wire psv_wr_t      wiper_wr_in,
  input  wire logic         ptr_wr_in,
  input  wire logic [7:0]   ptr_data_in,
  output psv_ctrl_t         ctrl_out,
  output logic [7:0]        wiper_out,
  output logic [7:0]        sink_code_out,
  output logic [7:0]        word_select_pointer_out,
  output logic              nv_write_out,
  output logic [7:0]        nv_data_out,
  output logic              load_done_out,
  output psv_state_t        state_out
);
  psv_sense_t           sense;
  logic [2:0]           sense_raw;
  psv_state_t           state_q;
  psv_state_t           state_d;
  logic [TIMER_W-1:0]   timer_q;
  logic [TIMER_W-1:0]   timer_d;
  logic [7:0]           wiper_q;
  logic [7:0]           wiper_d;
  logic [7:0]           ptr_q;
  logic [7:0]           ptr_d;
  logic                 nv_wr_q;
  logic                 nv_wr_d;
  logic [7:0]           nv_data_q;
  logic [7:0]           nv_data_d;
  psv_ctrl_t            ctrl_q;
  psv_ctrl_t            ctrl_d;
  logic                 ext_en_meta_q;
  logic                 ext_en_q;

  function automatic logic [7:0] sink_code(input logic [7:0] w);
    sink_code = WIPER_FULL - w;
  endfunction : sink_code

  function automatic logic [TIMER_W-1:0] cnt_val(input int unsigned c);
    cnt_val = TIMER_W'(c - 1);
  endfunction : cnt_val

  assign sense_raw = {lockout_in, rail_good_in, delay_charged_in};
  psv_sync #(.WIDTH(3)) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   (sense_raw),
    .rst_val_in (3'b100),
    .sync_out   (sense)
  );

  // enable pin is also external; synchronised inline
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_en_meta_q <= 1'b0;
      ext_en_q      <= 1'b0;
    end else if (clk_en_in) begin
      ext_en_meta_q <= ext_enable_in;
      ext_en_q      <= ext_en_meta_q;
    end
  end

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    unique case (state_q)
      PSV_ST_LOCKOUT: begin
        if (!sense.lockout) begin
          state_d = PSV_ST_LOAD;
          timer_d = cnt_val(LOAD_CNT);
        end
      end
      PSV_ST_LOAD: begin
        if (timer_q == '0) begin
          state_d = PSV_ST_SOFT;
          timer_d = cnt_val(SOFT_CNT);
        end else begin
          timer_d = timer_q - 1'b1;
        end
      end
      // soft-start interval of the logic regulator
      PSV_ST_SOFT: begin
        if (timer_q == '0) begin
          state_d = PSV_ST_WAIT_EN;
        end else begin
          timer_d = timer_q - 1'b1;
        end
      end
      PSV_ST_WAIT_EN: begin
        if (sense.rail_good && ext_en_q) begin
          state_d = PSV_ST_BOOST;
        end
      end
      PSV_ST_BOOST: begin
        if (!(sense.rail_good && ext_en_q)) begin
          state_d = PSV_ST_WAIT_EN;
        end else if (sense.delay_charged) begin
          state_d = PSV_ST_RUN;
        end
      end
      PSV_ST_RUN: begin
        if (!(sense.rail_good && ext_en_q)) begin
          state_d = PSV_ST_WAIT_EN;
        end
      end
      default: begin
        state_d = PSV_ST_LOCKOUT;
        timer_d = '0;
      end
    endcase
    // lockout returns to reset from any state
    if (sense.lockout) begin
      state_d = PSV_ST_LOCKOUT;
      timer_d = '0;
    end
  end

  always_comb begin
    ctrl_d.ldo_enable         = 1'b0;
    ctrl_d.boost_enable       = 1'b0;
    ctrl_d.gate_pulse_release = 1'b0;
    if ((state_d != PSV_ST_LOCKOUT) && (state_d != PSV_ST_LOAD)) begin
      ctrl_d.ldo_enable = 1'b1;
    end
    // boost gated by rail good and enable
    if ((state_d == PSV_ST_BOOST) || (state_d == PSV_ST_RUN)) begin
      ctrl_d.boost_enable = 1'b1;
    end
    // gate pulse held until delay node charged
    if (state_d == PSV_ST_RUN) begin
      ctrl_d.gate_pulse_release = 1'b1;
    end
  end

  always_comb begin
    wiper_d   = wiper_q;
    ptr_d     = ptr_q;
    nv_wr_d   = 1'b0;
    nv_data_d = nv_data_q;
    // lockout seen this cycle also blocks a pointer write landing with it
    if ((state_q == PSV_ST_LOCKOUT) || sense.lockout) begin
      wiper_d = WIPER_DEFAULT;
      ptr_d   = PTR_NV_WORD;
    end else if (state_q == PSV_ST_LOAD) begin
      // recall stored initial word at end of load
      if (timer_q == '0) begin
        wiper_d = stored_initial_wiper_in;
      end
    end else begin
      if (ptr_wr_in) begin
        ptr_d = ptr_data_in;
      end
      // volatile writes and stored writes both move the wiper
      if (wiper_wr_in.write) begin
        wiper_d = wiper_wr_in.data;
        if (!ptr_q[PTR_SEL_BIT]) begin
          nv_wr_d   = 1'b1;
          nv_data_d = wiper_wr_in.data;
        end
      end
      // bus error wins over a write in the same cycle
      if (bus_error_in) begin
        wiper_d = WIPER_DEFAULT;
        nv_wr_d = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q   <= PSV_ST_LOCKOUT;
      timer_q   <= '0;
      wiper_q   <= WIPER_DEFAULT;
      ptr_q     <= PTR_NV_WORD;
      nv_wr_q   <= 1'b0;
      nv_data_q <= WIPER_DEFAULT;
      ctrl_q    <= '0;
    end else if (clk_en_in) begin
      state_q   <= state_d;
      timer_q   <= timer_d;
      wiper_q   <= wiper_d;
      ptr_q     <= ptr_d;
      nv_wr_q   <= nv_wr_d;
      nv_data_q <= nv_data_d;
      ctrl_q    <= ctrl_d;
    end
  end

  assign ctrl_out                = ctrl_q;
  assign wiper_out               = wiper_q;
  assign sink_code_out           = sink_code(wiper_q);
  assign word_select_pointer_out = ptr_q;
  assign nv_write_out            = nv_wr_q;
  assign nv_data_out             = nv_data_q;
  assign load_done_out           = ctrl_q.ldo_enable;
  assign state_out               = state_q;

  chk_load_len: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(ctrl_q.ldo_enable) |-> ($past(state_q) == PSV_ST_LOAD) && ($past(timer_q) == '0))
    else $error("regulator enabled before load finished");
  chk_load_start: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    ((state_q == PSV_ST_LOAD) && ($past(state_q) == PSV_ST_LOCKOUT))
      |-> (timer_q == cnt_val(LOAD_CNT)))
    else $error("load timer not started at full count");
  chk_ldo_after: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    ctrl_q.ldo_enable |-> (state_q != PSV_ST_LOCKOUT) && (state_q != PSV_ST_LOAD))
    else $error("regulator on in lockout or load");
  chk_boost_gate: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(ctrl_q.boost_enable) |-> $past(sense.rail_good) && $past(ext_en_q))
    else $error("boost started without rail and enable");
  chk_gate_hold: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(ctrl_q.gate_pulse_release) |-> $past(sense.delay_charged))
    else $error("gate output released early");
  chk_err_default: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (bus_error_in && clk_en_in && state_q != PSV_ST_LOAD) |=> (wiper_q == WIPER_DEFAULT))
    else $error("wiper not restored after bus error");
  chk_sink_code: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (sink_code_out + wiper_out) == WIPER_FULL)
    else $error("sink code mismatch");
  chk_recall: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (state_q == PSV_ST_LOAD && timer_q == '0 && clk_en_in && !sense.lockout)
      |=> (wiper_q == $past(stored_initial_wiper_in)))
    else $error("stored word not recalled");
  chk_lockout_rst: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    (sense.lockout && clk_en_in) |=> (state_q == PSV_ST_LOCKOUT) && (ptr_q == PTR_NV_WORD)
      ##1 (!clk_en_in || !ctrl_q.ldo_enable))
    else $error("lockout did not reset sequencer");
endmodule : psv_seq

// ---- hdl/psv_sync.sv ----
// psv_sync: two-flop synchroniser bank for asynchronous comparator levels
// assumes inputs are slow analog levels; no pulses shorter than a cycle
`timescale 1ns/1ps
module psv_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // bits whose reset level is low are held inverted, so the flops reset to a constant
  always_comb begin
    meta_d = clk_en_in ? (async_in ^ ~rst_val_in) : meta_q;
    sync_d = clk_en_in ? meta_q : sync_q;
  end

  // reset to all ones: lockout asserted, others read as inactive by caller
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q ^ ~rst_val_in;
endmodule : psv_sync

// ---- test/psv_analog_model.sv ----
// psv_analog_model: behavioural logic regulator and delay-node comparator
// assumes enables from the sequencer; levels change just after a clock edge
`timescale 1ns/1ps
module psv_analog_model
  import psv_pkg::*;
#(
  parameter int unsigned RISE_CYC = 6
) (
  input  wire logic      ref_clk_in,
  input  wire logic      reset_n_in,
  input  wire psv_ctrl_t ctrl_in,
  output logic           rail_good_out,
  output logic           delay_charged_out
);
  logic [7:0] rail_cnt_q;
  logic [7:0] dly_cnt_q;
  // rail ramps only while the regulator is enabled; node charges only with boost on
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rail_cnt_q <= 8'h00;
      dly_cnt_q  <= 8'h00;
    end else begin
      rail_cnt_q <= !ctrl_in.ldo_enable ? 8'h00 : rail_cnt_q + 8'(rail_cnt_q != 8'(RISE_CYC));
      dly_cnt_q  <= !ctrl_in.boost_enable ? 8'h00 : dly_cnt_q + 8'(dly_cnt_q != 8'(RISE_CYC));
    end
  end
  assign rail_good_out     = (rail_cnt_q == 8'(RISE_CYC));
  assign delay_charged_out = (dly_cnt_q == 8'(RISE_CYC));
endmodule : psv_analog_model

// ---- test/testbench.sv ----
// testbench: power-up order, wiper writes, bus errors and lockout return
// assumes short load and soft-start counts so the run stays small
`timescale 1ns/1ps
module testbench;
  import psv_pkg::*;
  localparam int LOAD_N = 4;
  localparam int SOFT_N = 8;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic lockout_in = 1'b1;
  logic ext_enable_in = 1'b0;
  logic [7:0] stored_initial_wiper_in = 8'h00;
  logic bus_error_in = 1'b0;
  psv_wr_t wiper_wr_in = '0;
  logic ptr_wr_in = 1'b0;
  logic [7:0] ptr_data_in = 8'h00;
  logic rail_good_in;
  logic delay_charged_in;
  psv_ctrl_t ctrl_out;
  psv_state_t state_out;
  logic [7:0] wiper_out, sink_code_out, word_select_pointer_out, nv_data_out;
  logic nv_write_out, load_done_out;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] rng = 32'h754A;
  always #25 ref_clk_in = ~ref_clk_in;
  psv_seq #(.LOAD_CNT(LOAD_N), .SOFT_CNT(SOFT_N)) psv_seq_inst (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .lockout_in(lockout_in), .rail_good_in(rail_good_in),
    .delay_charged_in(delay_charged_in), .ext_enable_in(ext_enable_in),
    .stored_initial_wiper_in(stored_initial_wiper_in), .bus_error_in(bus_error_in),
    .wiper_wr_in(wiper_wr_in), .ptr_wr_in(ptr_wr_in), .ptr_data_in(ptr_data_in),
    .ctrl_out(ctrl_out), .wiper_out(wiper_out), .sink_code_out(sink_code_out),
    .word_select_pointer_out(word_select_pointer_out), .nv_write_out(nv_write_out),
    .nv_data_out(nv_data_out), .load_done_out(load_done_out), .state_out(state_out));
  psv_analog_model psv_analog_model_inst (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .ctrl_in(ctrl_out),
    .rail_good_out(rail_good_in), .delay_charged_out(delay_charged_in));
  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : next_rand
  function automatic logic [7:0] exp_sink(input logic [7:0] w);
    return 8'hFF - w;
  endfunction : exp_sink
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask : check
  task automatic tick();
    @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic wait_state(input psv_state_t s);
    int n;
    n = 0;
    while (state_out !== s && n < 300) begin
      tick();
      n++;
    end
    check({2'h0, state_out}, {2'h0, s});
    if (state_out !== s) give_verdict();
  endtask : wait_state
  task automatic wr_word(input logic [7:0] d, input logic err);
    wiper_wr_in = '{write: 1'b1, to_nv: 1'b0, data: d};
    bus_error_in = err;
    tick();
    wiper_wr_in = '0;
    bus_error_in = 1'b0;
  endtask : wr_word
  task automatic set_ptr(input logic [7:0] p);
    ptr_wr_in = 1'b1;
    ptr_data_in = p;
    tick();
    ptr_wr_in = 1'b0;
  endtask : set_ptr
  initial begin
    logic [7:0] d, p;
    int n;
    repeat (3) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    tick();
    check(wiper_out, 8'h80);
    check(sink_code_out, 8'h7F);
    check(word_select_pointer_out, 8'h00);
    wr_word(8'h12, 1'b0);
    check(wiper_out, 8'h80);
    $display("test reset done");
    stored_initial_wiper_in = 8'(next_rand());
    lockout_in = 1'b0;
    wait_state(PSV_ST_LOAD);
    n = 0;
    while (state_out === PSV_ST_LOAD && n < 50) begin
      check({5'h0, ctrl_out}, 8'h00);
      tick();
      n++;
    end
    check(n[7:0], 8'(LOAD_N));
    check(wiper_out, stored_initial_wiper_in);
    n = 0;
    while (state_out === PSV_ST_SOFT && n < 50) begin
      check({7'h0, ctrl_out.ldo_enable}, 8'h01);
      tick();
      n++;
    end
    check(n[7:0], 8'(SOFT_N));
    wait_state(PSV_ST_WAIT_EN);
    repeat (10) tick();
    check({6'h0, rail_good_in, ctrl_out.boost_enable}, 8'h02);
    ext_enable_in = 1'b1;
    wait_state(PSV_ST_BOOST);
    check({6'h0, ctrl_out.boost_enable, ctrl_out.gate_pulse_release}, 8'h02);
    wait_state(PSV_ST_RUN);
    check({6'h0, delay_charged_in, ctrl_out.gate_pulse_release}, 8'h03);
    // clock enable low: a write must not land and the state must hold
    clk_en_in = 1'b0;
    wr_word(~stored_initial_wiper_in, 1'b0);
    repeat (3) tick();
    check(wiper_out, stored_initial_wiper_in);
    check({2'h0, state_out}, {2'h0, PSV_ST_RUN});
    clk_en_in = 1'b1;
    $display("test power-up done");
    for (int i = 0; i < 8; i++) begin
      p = (i % 2) ? PTR_VOL_WORD : PTR_NV_WORD;
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(next_rand());
      set_ptr(p);
      wr_word(d, 1'b0);
      check(word_select_pointer_out, p);
      check(wiper_out, d);
      check(sink_code_out, exp_sink(d));
      check({7'h0, nv_write_out}, {7'h0, ~p[7]});
      if (!p[7]) check(nv_data_out, d);
    end
    $display("test wiper writes done");
    wr_word(8'h3C, 1'b0);
    check(wiper_out, 8'h3C);
    tick();
    bus_error_in = 1'b1;
    tick();
    bus_error_in = 1'b0;
    check(wiper_out, 8'h80);
    set_ptr(PTR_NV_WORD);
    wr_word(8'h55, 1'b1);
    check(wiper_out, 8'h80);
    check({7'h0, nv_write_out}, 8'h00);
    $display("test bus error done");
    ext_enable_in = 1'b0;
    wait_state(PSV_ST_WAIT_EN);
    check({6'h0, ctrl_out.boost_enable, ctrl_out.gate_pulse_release}, 8'h00);
    set_ptr(PTR_VOL_WORD);
    lockout_in = 1'b1;
    wait_state(PSV_ST_LOCKOUT);
    check({5'h0, ctrl_out}, 8'h00);
    check(wiper_out, 8'h80);
    check(word_select_pointer_out, PTR_NV_WORD);
    $display("test lockout done");
    reset_n_in = 1'b0;
    tick();
    reset_n_in = 1'b1;
    tick();
    check({2'h0, state_out}, {2'h0, PSV_ST_LOCKOUT});
    check(wiper_out, 8'h80);
    stored_initial_wiper_in = 8'(next_rand());
    lockout_in = 1'b0;
    wait_state(PSV_ST_SOFT);
    check(wiper_out, stored_initial_wiper_in);
    $display("test restart done");
    give_verdict();
  end
endmodule : testbench
